// file: logic/ieg_consts.svh
// Register addresses, field positions and reset values of the interrupt enable gating block.
`ifndef IEG_CONSTS_SVH
`define IEG_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define IEG_ADDR_W 16
`define IEG_ENABLE0_IDX 14'h0716
`define IEG_ENABLE0_ADDR {`IEG_ENABLE0_IDX, 2'b00}
`define IEG_CTRL_ADDR 16'h0000
`define IEG_FLAG0_ADDR 16'h0004
`define IEG_PEN_ADDR 16'h0008
`define IEG_PFLAG_ADDR 16'h000c
`define IEG_EXTSEL_ADDR 16'h0010
`define IEG_EVT_STAT_ADDR 16'h0014
`define IEG_EVT_MASK_ADDR 16'h0018
`define IEG_REQ_STAT_ADDR 16'h001c

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define IEG_TMR0_BIT 5
`define IEG_PINCHG_BIT 4
`define IEG_EXT_BIT 0
`define IEG_EN0_MASK 8'h31
`define IEG_EN0_RST 8'h00
`define IEG_CTRL_GIE_BIT 7
`define IEG_CTRL_PERIPHERAL_IRQ_GATE_BIT 6
`define IEG_CTRL_EDGE_BIT 0
`define IEG_CTRL_RST 8'h01
`define IEG_EVT_W 4
`define IEG_EVT_MASK_RST 4'h0
`define IEG_RESP_OKAY 2'b00
`define IEG_RESP_SLVERR 2'b10

`endif

// file: logic/ieg_pkg.sv
// Types shared by the interrupt enable gating design.
package ieg_pkg;
    typedef logic [31:0] ieg_word_t;
    typedef logic [15:0] ieg_addr_t;
    typedef logic [1:0] ieg_resp_t;
    typedef enum logic {
        IEG_WR_COLLECT = 1'b0,
        IEG_WR_RESP = 1'b1
    } ieg_wr_state_e;
    typedef enum logic {
        IEG_RD_IDLE = 1'b0,
        IEG_RD_VALID = 1'b1
    } ieg_rd_state_e;
endpackage : ieg_pkg

// file: logic/ieg_flag_if.sv
// Set, clear and state lines of one bank of sticky flags.
interface ieg_flag_if #(
    parameter int W = 8
);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] flags;
    modport bank (input set, input clr, output flags);
    modport user (output set, output clr, input flags);
endinterface : ieg_flag_if

// file: logic/ieg_flag_bank.sv
// Bank of sticky flags in which a hardware set beats a same-cycle clear.
module ieg_flag_bank #(
    parameter int W = 8
) (
    input logic clock, // System clock.
    input logic rst, // Synchronous reset, active high.
    input logic ce, // Clock enable; state holds while low.
    ieg_flag_if.bank port // Set, clear and flag lines.
);
    import ieg_pkg::*;

    logic [W-1:0] flags_r;

    // A flag latches whatever its enables say; an event in the clear cycle survives.
    always_ff @(posedge clock) begin
        if (rst) begin
            flags_r <= '0;
        end else if (ce) begin
            flags_r <= (flags_r & ~port.clr) | port.set; // RL7
        end
    end

    assign port.flags = flags_r;
endmodule : ieg_flag_bank

// file: logic/ieg_ext_select.sv
// Pin selector and edge detector for the external interrupt input.
module ieg_ext_select #(
    parameter int N_PINS = 32,
    parameter int SEL_W = 5
) (
    input logic clock, // System clock.
    input logic rst, // Synchronous reset, active high.
    input logic ce, // Clock enable; state holds while low.
    input logic [N_PINS-1:0] pins, // Candidate input pins.
    input logic [SEL_W-1:0] sel, // Pin chosen as the external input.
    input logic risingEdge, // 1 detects rising edges, 0 falling.
    output logic edgePulse // One-cycle pulse per detected edge.
);
    import ieg_pkg::*;

    logic pinNow;
    logic pinPrev_r;
    logic [SEL_W-1:0] selPrev_r;
    logic pulse_r;

    assign pinNow = (int'(sel) < N_PINS) ? pins[sel] : 1'b0; // RL4

    always_ff @(posedge clock) begin
        if (rst) begin
            pinPrev_r <= 1'b0;
            selPrev_r <= '0;
        end else if (ce) begin
            pinPrev_r <= pinNow;
            selPrev_r <= sel;
        end
    end

    // Moving the selector compares two different pins, so that cycle never reports an edge.
    always_ff @(posedge clock) begin
        if (rst) begin
            pulse_r <= 1'b0;
        end else if (ce) begin
            pulse_r <= (sel == selPrev_r) &&
                (risingEdge ? (pinNow && !pinPrev_r) : (!pinNow && pinPrev_r)); // RL4
        end
    end

    assign edgePulse = pulse_r;
endmodule : ieg_ext_select

// file: logic/ieg_irq_top.sv
// Interrupt enable gating with an AXI4-Lite register slave.
// ----------------------------------------------------------------------------
// How it works
// RL1 - Enable register bit 5 gates the Timer0 interrupt; read/write, resets to 0.
// RL2 - Enable register bit 4 gates the pin-change interrupt; read/write, resets to 0.
// RL3 - Enable register bit 0 gates the external pin interrupt; read/write, resets to 0.
// RL4 - The external interrupt comes from the pin the input select register names.
// RL5 - Peripheral sources interrupt only while the peripheral gate bit is also set.
// RL6 - Group zero sources need only their enable and global enable, not the gate.
// RL7 - Pending flags latch on their event whatever the enable or global bits.
// RL8 - Software clears pending flags before setting the matching enable bit.
// RL9 - Request is OR of flag AND enable, qualified by global enable, with the peripheral gate on peripheral flags only.
// ----------------------------------------------------------------------------
`include "ieg_consts.svh"

module ieg_irq_top #(
    parameter int N_PERIPH = 8,
    parameter int N_PINS = 32,
    parameter int SEL_W = 5
) (
    input logic clock, // System clock, 250 MHz.
    input logic rst, // Synchronous reset, active high.
    input logic ce, // Clock enable; all state holds while low.
    input logic timer0Ovf, // Timer0 overflow event pulse.
    input logic pinChange, // Interrupt-on-change event pulse.
    input logic [N_PINS-1:0] extPins, // Pins the external input may use.
    input logic [N_PERIPH-1:0] periphEvt, // Peripheral event pulses.
    output logic coreIrqReq, // Interrupt request to the core.
    output logic irq, // Block interrupt from event status.
    input ieg_pkg::ieg_addr_t s_axi_awaddr, // Write address.
    input logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input ieg_pkg::ieg_word_t s_axi_wdata, // Write data.
    input logic [3:0] s_axi_wstrb, // Write byte strobes.
    input logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output ieg_pkg::ieg_resp_t s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input logic s_axi_bready, // Write response ready.
    input ieg_pkg::ieg_addr_t s_axi_araddr, // Read address.
    input logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output ieg_pkg::ieg_word_t s_axi_rdata, // Read data.
    output ieg_pkg::ieg_resp_t s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input logic s_axi_rready // Read data ready.
);
    import ieg_pkg::*;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic isMapped(input ieg_addr_t a);
        isMapped = (a == `IEG_ENABLE0_ADDR) || (a == `IEG_CTRL_ADDR) ||
            (a == `IEG_FLAG0_ADDR) || (a == `IEG_PEN_ADDR) ||
            (a == `IEG_PFLAG_ADDR) || (a == `IEG_EXTSEL_ADDR) ||
            (a == `IEG_EVT_STAT_ADDR) || (a == `IEG_EVT_MASK_ADDR) ||
            (a == `IEG_REQ_STAT_ADDR);
    endfunction : isMapped

    function automatic ieg_word_t zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction : zext8

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [7:0] en0_r;
    logic gie_r;
    logic peripheral_irq_gate_r;
    logic edgeRise_r;
    logic [N_PERIPH-1:0] pen_r;
    logic [SEL_W-1:0] extSel_r;
    logic [`IEG_EVT_W-1:0] evtMask_r;
    logic irqReq_r;
    logic irq_r;

    ieg_wr_state_e wrState_r;
    logic awHeld_r;
    ieg_addr_t awAddr_r;
    logic wHeld_r;
    ieg_word_t wData_r;
    logic [3:0] wStrb_r;
    ieg_resp_t bresp_r;

    ieg_rd_state_e rdState_r;
    ieg_word_t rdata_r;
    ieg_resp_t rresp_r;

    logic awFire;
    logic wFire;
    logic arFire;
    logic wrGo;
    ieg_addr_t wrAddr;
    ieg_word_t wrData;
    logic [3:0] wrStrb;
    ieg_word_t rdWord;
    logic extPulse;
    logic group0Req;
    logic periphReq;
    logic reqNxt;

    ieg_flag_if #(.W(8)) flag0 ();
    ieg_flag_if #(.W(N_PERIPH)) pflag ();
    ieg_flag_if #(.W(`IEG_EVT_W)) evt ();

    // ------------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------------
    // Address and data are parked independently so either may arrive first.
    assign s_axi_awready = ce && (wrState_r == IEG_WR_COLLECT) && !awHeld_r;
    assign s_axi_wready = ce && (wrState_r == IEG_WR_COLLECT) && !wHeld_r;
    assign awFire = s_axi_awvalid && s_axi_awready;
    assign wFire = s_axi_wvalid && s_axi_wready;
    assign wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
    assign wrData = wHeld_r ? wData_r : s_axi_wdata;
    assign wrStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
    assign wrGo = ce && (wrState_r == IEG_WR_COLLECT) &&
        (awHeld_r || awFire) && (wHeld_r || wFire);

    always_ff @(posedge clock) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
        end else if (wrGo) begin
            awHeld_r <= 1'b0;
        end else if (awFire) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wHeld_r <= 1'b0;
            wData_r <= '0;
            wStrb_r <= '0;
        end else if (wrGo) begin
            wHeld_r <= 1'b0;
        end else if (wFire) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wrState_r <= IEG_WR_COLLECT;
            bresp_r <= `IEG_RESP_OKAY;
        end else if (ce) begin
            case (wrState_r)
                IEG_WR_COLLECT: begin
                    if (wrGo) begin
                        wrState_r <= IEG_WR_RESP;
                        bresp_r <= isMapped(wrAddr) ? `IEG_RESP_OKAY : `IEG_RESP_SLVERR;
                    end
                end
                IEG_WR_RESP: begin
                    if (s_axi_bready) begin
                        wrState_r <= IEG_WR_COLLECT;
                    end
                end
                default: begin
                    wrState_r <= IEG_WR_COLLECT;
                end
            endcase
        end
    end

    assign s_axi_bvalid = (wrState_r == IEG_WR_RESP);
    assign s_axi_bresp = bresp_r;

    // ------------------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------------------
    // Only the low byte lane carries register bits, so byte strobe 0 gates every write.
    always_ff @(posedge clock) begin
        if (rst) begin
            en0_r <= `IEG_EN0_RST; // RL1 RL2 RL3
        end else if (wrGo && wrStrb[0] && wrAddr == `IEG_ENABLE0_ADDR) begin
            en0_r <= wrData[7:0] & `IEG_EN0_MASK; // RL1 RL2 RL3
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            gie_r <= 1'(`IEG_CTRL_RST >> `IEG_CTRL_GIE_BIT);
            peripheral_irq_gate_r <= 1'(`IEG_CTRL_RST >> `IEG_CTRL_PERIPHERAL_IRQ_GATE_BIT);
            edgeRise_r <= 1'(`IEG_CTRL_RST >> `IEG_CTRL_EDGE_BIT);
        end else if (wrGo && wrStrb[0] && wrAddr == `IEG_CTRL_ADDR) begin
            gie_r <= wrData[`IEG_CTRL_GIE_BIT];
            peripheral_irq_gate_r <= wrData[`IEG_CTRL_PERIPHERAL_IRQ_GATE_BIT];
            edgeRise_r <= wrData[`IEG_CTRL_EDGE_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pen_r <= '0;
        end else if (wrGo && wrStrb[0] && wrAddr == `IEG_PEN_ADDR) begin
            pen_r <= wrData[N_PERIPH-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            extSel_r <= '0;
        end else if (wrGo && wrStrb[0] && wrAddr == `IEG_EXTSEL_ADDR) begin
            extSel_r <= wrData[SEL_W-1:0]; // RL4
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            evtMask_r <= `IEG_EVT_MASK_RST;
        end else if (wrGo && wrStrb[0] && wrAddr == `IEG_EVT_MASK_ADDR) begin
            evtMask_r <= wrData[`IEG_EVT_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Sources and pending flags
    // ------------------------------------------------------------------------
    ieg_ext_select #(
        .N_PINS(N_PINS),
        .SEL_W(SEL_W)
    ) u_ext (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .pins(extPins),
        .sel(extSel_r),
        .risingEdge(edgeRise_r),
        .edgePulse(extPulse)
    );

    // Flags set on the raw event, never looking at an enable.
    always_comb begin
        flag0.set = '0;
        flag0.set[`IEG_TMR0_BIT] = timer0Ovf; // RL7
        flag0.set[`IEG_PINCHG_BIT] = pinChange; // RL7
        flag0.set[`IEG_EXT_BIT] = extPulse; // RL7
    end

    // Pending flags are write-one-to-clear, which lets software drop stale events first.
    assign flag0.clr = (wrGo && wrStrb[0] && wrAddr == `IEG_FLAG0_ADDR) ?
        (wrData[7:0] & `IEG_EN0_MASK) : 8'h00; // RL8
    assign pflag.set = periphEvt; // RL7
    assign pflag.clr = (wrGo && wrStrb[0] && wrAddr == `IEG_PFLAG_ADDR) ?
        wrData[N_PERIPH-1:0] : '0; // RL8

    ieg_flag_bank #(
        .W(8)
    ) u_flag0 (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .port(flag0.bank)
    );

    ieg_flag_bank #(
        .W(N_PERIPH)
    ) u_pflag (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .port(pflag.bank)
    );

    // ------------------------------------------------------------------------
    // Request to the core
    // ------------------------------------------------------------------------
    assign group0Req = |(flag0.flags & en0_r); // RL1 RL2 RL3 RL6
    assign periphReq = peripheral_irq_gate_r && |(pflag.flags & pen_r); // RL5
    assign reqNxt = gie_r && (group0Req || periphReq); // RL9

    always_ff @(posedge clock) begin
        if (rst) begin
            irqReq_r <= 1'b0;
        end else if (ce) begin
            irqReq_r <= reqNxt; // RL9
        end
    end

    assign coreIrqReq = irqReq_r;

    // ------------------------------------------------------------------------
    // Event status, mask and block interrupt
    // ------------------------------------------------------------------------
    assign evt.set = {|periphEvt, extPulse, pinChange, timer0Ovf};
    assign evt.clr = (arFire && s_axi_araddr == `IEG_EVT_STAT_ADDR) ?
        {`IEG_EVT_W{1'b1}} : '0;

    ieg_flag_bank #(
        .W(`IEG_EVT_W)
    ) u_evt (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .port(evt.bank)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= |(evt.flags & evtMask_r);
        end
    end

    assign irq = irq_r;

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    always_comb begin
        rdWord = '0;
        case (s_axi_araddr)
            `IEG_ENABLE0_ADDR: rdWord = zext8(en0_r);
            `IEG_CTRL_ADDR: begin
                rdWord[`IEG_CTRL_GIE_BIT] = gie_r;
                rdWord[`IEG_CTRL_PERIPHERAL_IRQ_GATE_BIT] = peripheral_irq_gate_r;
                rdWord[`IEG_CTRL_EDGE_BIT] = edgeRise_r;
            end
            `IEG_FLAG0_ADDR: rdWord = zext8(flag0.flags);
            `IEG_PEN_ADDR: rdWord = 32'(pen_r);
            `IEG_PFLAG_ADDR: rdWord = 32'(pflag.flags);
            `IEG_EXTSEL_ADDR: rdWord = 32'(extSel_r);
            `IEG_EVT_STAT_ADDR: rdWord = 32'(evt.flags);
            `IEG_EVT_MASK_ADDR: rdWord = 32'(evtMask_r);
            `IEG_REQ_STAT_ADDR: rdWord = {29'h0, periphReq, group0Req, irqReq_r};
            default: rdWord = '0;
        endcase
    end

    assign s_axi_arready = ce && (rdState_r == IEG_RD_IDLE);
    assign arFire = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clock) begin
        if (rst) begin
            rdState_r <= IEG_RD_IDLE;
            rdata_r <= '0;
            rresp_r <= `IEG_RESP_OKAY;
        end else if (ce) begin
            case (rdState_r)
                IEG_RD_IDLE: begin
                    if (arFire) begin
                        rdState_r <= IEG_RD_VALID;
                        rdata_r <= rdWord;
                        rresp_r <= isMapped(s_axi_araddr) ? `IEG_RESP_OKAY : `IEG_RESP_SLVERR;
                    end
                end
                IEG_RD_VALID: begin
                    if (s_axi_rready) begin
                        rdState_r <= IEG_RD_IDLE;
                    end
                end
                default: begin
                    rdState_r <= IEG_RD_IDLE;
                end
            endcase
        end
    end

    assign s_axi_rvalid = (rdState_r == IEG_RD_VALID);
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule : ieg_irq_top

// file: verif/ieg_core_model.sv
// Behavioural model of the core's interrupt vectoring logic.
module ieg_core_model (
    input wire logic clock, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic irqReq, // Request from the gating block.
    output logic [7:0] vectorCnt // Times the core has vectored.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic reqSeen_r;
    // A level request vectors once; the handler must clear its source first.
    always_ff @(posedge clock) begin
        if (rst) begin
            reqSeen_r <= 1'b0;
            vectorCnt <= 8'h00;
        end else begin
            reqSeen_r <= irqReq;
            if (irqReq && !reqSeen_r) begin
                vectorCnt <= vectorCnt + 8'h01;
            end
        end
    end
endmodule : ieg_core_model

// file: verif/ieg_irq_sva.sv
// Port-level assertions for the interrupt enable gating block.
module ieg_irq_sva (
    input logic clock, // System clock.
    input logic rst, // Reset.
    input logic ce, // Clock enable.
    input logic coreIrqReq, // Core request.
    input logic irq, // Block interrupt.
    input logic s_axi_awvalid, // Bus.
    input logic s_axi_awready, // Bus.
    input logic s_axi_wvalid, // Bus.
    input logic s_axi_wready, // Bus.
    input logic s_axi_bvalid, // Bus.
    input logic s_axi_bready, // Bus.
    input logic s_axi_arvalid, // Bus.
    input logic s_axi_arready, // Bus.
    input ieg_pkg::ieg_word_t s_axi_rdata, // Bus.
    input logic s_axi_rvalid, // Bus.
    input logic s_axi_rready // Bus.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready && ce;
    endsequence
    property p_reset_quiet;
        $fell(rst) |-> !coreIrqReq && !irq && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    property p_wr_answer;
        s_wr_taken |=> s_axi_bvalid;
    endproperty
    property p_rd_answer;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    property p_rd_hold;
        s_axi_rvalid && !(s_axi_rready && ce) |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_b_hold;
        s_axi_bvalid && !(s_axi_bready && ce) |=> s_axi_bvalid;
    endproperty
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_ce_freeze;
        !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready;
    endproperty
    // Requests only drop when software has written a clear or a disable.
    property p_req_fall;
        $fell(coreIrqReq) |-> $past(s_axi_bvalid);
    endproperty
    property p_irq_fall;
        $fell(irq) |-> $past(s_axi_rvalid || s_axi_bvalid)
            || $past(s_axi_rvalid || s_axi_bvalid, 2);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
    a_wr_answer: assert property (p_wr_answer)
        else $error("no write response");
    a_rd_answer: assert property (p_rd_answer)
        else $error("no read response");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read answer not held");
    a_b_hold: assert property (p_b_hold)
        else $error("write answer not held");
    a_ar_block: assert property (p_ar_block)
        else $error("read taken while answer pending");
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("ready while clock enable low");
    a_req_fall: assert property (p_req_fall)
        else $error("request dropped without a write");
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without access");
endmodule : ieg_irq_sva

bind ieg_irq_top ieg_irq_sva u_sva (
    .clock(clock), .rst(rst), .ce(ce), .coreIrqReq(coreIrqReq), .irq(irq),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// file: verif/tb_irq_enable_gating.sv
// Self-checking bench for the interrupt enable gating block.
`include "ieg_consts.svh"
module tb_irq_enable_gating import ieg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, ce = 1'b1, timer0Ovf = 1'b0, pinChange = 1'b0;
    logic [31:0] extPins = '0;
    logic [7:0] periphEvt = '0;
    logic [7:0] vectorCnt;
    ieg_addr_t awaddr = '0, araddr = '0;
    ieg_word_t wdata = '0, rdata;
    ieg_resp_t bresp, rresp;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, coreIrqReq, irq;
    int failures = 0, n_tests = 0, cycles = 0;

    ieg_irq_top dut (.clock(clock), .rst(rst), .ce(ce), .timer0Ovf(timer0Ovf),
        .pinChange(pinChange), .extPins(extPins), .periphEvt(periphEvt),
        .coreIrqReq(coreIrqReq), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ieg_core_model core (.clock(clock), .rst(rst), .irqReq(coreIrqReq), .vectorCnt(vectorCnt));

    initial begin
        forever #2 clock = ~clock;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic chkReq(input logic e);
        chk("coreIrqReq", {31'h0, coreIrqReq}, {31'h0, e});
    endtask : chkReq

    task automatic wr(input ieg_addr_t a, input ieg_word_t d,
        input ieg_resp_t er = `IEG_RESP_OKAY);
        logic awT, wT, bT;
        ieg_resp_t r;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(negedge clock);
            awT = awvalid && awready;
            wT = wvalid && wready;
            bT = bvalid;
            r = bresp;
            @(posedge clock);
            if (awT) awvalid <= 1'b0;
            if (wT) wvalid <= 1'b0;
        end while (!bT);
        bready <= 1'b0;
        @(negedge clock);
        chk("bresp", {30'h0, r}, {30'h0, er});
    endtask : wr

    task automatic rdc(input string what, input ieg_addr_t a, input ieg_word_t e,
        input ieg_resp_t er = `IEG_RESP_OKAY);
        logic arT, rT;
        ieg_word_t d;
        ieg_resp_t r;
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(negedge clock);
            arT = arvalid && arready;
            rT = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (arT) arvalid <= 1'b0;
        end while (!rT);
        rready <= 1'b0;
        @(negedge clock);
        chk(what, d, e);
        chk("rresp", {30'h0, r}, {30'h0, er});
    endtask : rdc

    // Source 0 timer, 1 pin change, 2 peripheral 0, 3 and up external pin k-3.
    task automatic pulse(input int k);
        @(posedge clock);
        case (k)
            0: timer0Ovf <= 1'b1;
            1: pinChange <= 1'b1;
            2: periphEvt <= 8'h01;
            default: extPins[k-3] <= 1'b1;
        endcase
        @(posedge clock);
        timer0Ovf <= 1'b0;
        pinChange <= 1'b0;
        periphEvt <= 8'h00;
        extPins <= '0;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask : pulse

    task automatic t_regs();
        rdc("enable0", `IEG_ENABLE0_ADDR, 32'h0);
        rdc("ctrl", `IEG_CTRL_ADDR, 32'h1);
        wr(`IEG_ENABLE0_ADDR, 32'hff);
        rdc("enable0", `IEG_ENABLE0_ADDR, 32'h31);
        wr(`IEG_ENABLE0_ADDR, 32'h0);
        wr(16'h0040, 32'h1, `IEG_RESP_SLVERR);
        rdc("unmapped", 16'h0040, 32'h0, `IEG_RESP_SLVERR);
        rdc("misaligned", 16'h0002, 32'h0, `IEG_RESP_SLVERR);
        $display("test registers done");
    endtask : t_regs

    task automatic t_latch();
        wr(`IEG_EXTSEL_ADDR, 32'h3);
        pulse(0);
        pulse(1);
        pulse(8);
        rdc("flag0", `IEG_FLAG0_ADDR, 32'h30);
        pulse(6);
        rdc("flag0", `IEG_FLAG0_ADDR, 32'h31);
        chkReq(1'b0);
        wr(`IEG_FLAG0_ADDR, 32'h31);
        rdc("flag0", `IEG_FLAG0_ADDR, 32'h0);
        $display("test latch done");
    endtask : t_latch

    task automatic t_group0();
        int src[3] = '{0, 1, 6};
        logic [7:0] v;
        wr(`IEG_ENABLE0_ADDR, 32'h31);
        pulse(0);
        chkReq(1'b0);
        wr(`IEG_CTRL_ADDR, 32'h81);
        chkReq(1'b1);
        wr(`IEG_FLAG0_ADDR, 32'h31);
        foreach (src[i]) begin
            v = vectorCnt;
            pulse(src[i]);
            chkReq(1'b1);
            chk("vectors", {24'h0, vectorCnt}, {24'h0, v + 8'h01});
            wr(`IEG_FLAG0_ADDR, 32'h31);
            chkReq(1'b0);
        end
        $display("test group0 done");
    endtask : t_group0

    task automatic t_periph();
        wr(`IEG_PEN_ADDR, 32'h1);
        pulse(2);
        chkReq(1'b0);
        rdc("pflag", `IEG_PFLAG_ADDR, 32'h1);
        wr(`IEG_CTRL_ADDR, 32'hc1);
        chkReq(1'b1);
        wr(`IEG_PFLAG_ADDR, 32'h1);
        chkReq(1'b0);
        $display("test peripheral done");
    endtask : t_periph

    task automatic t_irq();
        rdc("status", `IEG_EVT_STAT_ADDR, 32'hf);
        wr(`IEG_EVT_MASK_ADDR, 32'h1);
        pulse(0);
        chk("irq", {31'h0, irq}, 32'h1);
        rdc("status", `IEG_EVT_STAT_ADDR, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        pulse(1);
        chk("irq", {31'h0, irq}, 32'h0);
        rdc("status", `IEG_EVT_STAT_ADDR, 32'h2);
        $display("test irq done");
    endtask : t_irq

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        ce <= 1'b0;
        repeat (3) @(posedge clock);
        ce <= 1'b1;
        t_regs();
        t_latch();
        t_group0();
        t_periph();
        t_irq();
        end_of_test();
    end
endmodule : tb_irq_enable_gating
